// ==== include/spi_quirk_pkg.sv ====
package spi_quirk_pkg;
    localparam int WORD_W = 32;
    localparam int DATA_W = 16;
    localparam int LAST_XFER_BIT = 24;
    localparam int NUM_CS = 4;
    localparam int CS_IDX_W = 2;
    localparam int FIFO_DEPTH = 32;
    localparam int DIV_W = 8;
    localparam int LEN_W = 4;
    localparam int BITS_W = 5;
    localparam int EDGE_W = 6;
    localparam logic [BITS_W-1:0] BASE_BITS = 5'h08;
    localparam logic [BITS_W-1:0] DATA_BITS = 5'h10;
    localparam logic [DIV_W-1:0] DIV_FAST = 8'h01;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h02;
    localparam logic [LEN_W-1:0] LEN_BYTE = 4'h0;
    localparam logic [EDGE_W-1:0] EXTRA_EDGES = 6'h02;
    localparam logic SIZE_BYTE = 1'b0;
    localparam logic SIZE_HALF = 1'b1;

    typedef struct packed {
        logic [DIV_W-1:0] divider;
        logic [LEN_W-1:0] word_length;
        logic hold;
        logic idle_level;
        logic capture_phase;
    } cs_cfg_t;

    localparam cs_cfg_t CS_CFG_RESET = '{divider: DIV_RESET, word_length: LEN_BYTE,
        hold: 1'b0, idle_level: 1'b0, capture_phase: 1'b0};

    typedef enum logic [2:0] {
        st_idle,
        st_lead,
        st_shift,
        st_trail,
        st_glitch
    } engine_state_t;
endpackage : spi_quirk_pkg

// ==== include/word_stream_if.sv ====
`timescale 1ns/100ps
interface word_stream_if #(parameter int W = 32);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : word_stream_if

// ==== design/word_fifo.sv ====
`timescale 1ns/100ps
module word_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic flush,
    word_stream_if.snk wr_port,
    word_stream_if.src rd_port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic room;
    } fifo_state_t;

    fifo_state_t st_ff;
    fifo_state_t nxt_st;
    logic push;
    logic pop;

    // Ready comes from a stored flag so the top can hand it out straight from a flop.
    assign wr_port.ready = st_ff.room;
    assign rd_port.valid = (st_ff.count != '0);
    assign rd_port.data = st_ff.mem[st_ff.rd_ptr];

    always_comb begin
        nxt_st = st_ff;
        push = wr_port.valid && st_ff.room;
        pop = rd_port.ready && (st_ff.count != '0);
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = wr_port.data;
            nxt_st.wr_ptr = st_ff.wr_ptr + AW'(1);
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - (AW+1)'(1);
        end
        if (flush) begin
            nxt_st.wr_ptr = '0;
            nxt_st.rd_ptr = '0;
            nxt_st.count = '0;
        end
        nxt_st.room = (nxt_st.count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.room <= 1'b1;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
endmodule : word_fifo

// ==== design/cs_cfg_reg.sv ====
`timescale 1ns/100ps
module cs_cfg_reg (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic wr,
    input spi_quirk_pkg::cs_cfg_t wr_data,
    output spi_quirk_pkg::cs_cfg_t cfg
);
    typedef struct packed {
        spi_quirk_pkg::cs_cfg_t cfg;
    } cfg_state_t;

    cfg_state_t st_ff;
    cfg_state_t nxt_st;

    assign cfg = st_ff.cfg;

    always_comb begin
        nxt_st = st_ff;
        if (clear) begin
            nxt_st.cfg = spi_quirk_pkg::CS_CFG_RESET;
        end else if (wr) begin
            nxt_st.cfg = wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff.cfg <= spi_quirk_pkg::CS_CFG_RESET;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
endmodule : cs_cfg_reg

// ==== design/spi_quirk_ctrl.sv ====
`timescale 1ns/100ps
module spi_quirk_ctrl #(
    parameter int FIFO_DEPTH = spi_quirk_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic soft_reset_command,
    input wire logic enable_command,
    input wire logic disable_command,
    input wire logic master_select_bit,
    input wire logic single_target_mode,
    input wire logic [1:0] target_select,
    input wire logic csr_write,
    input wire logic [1:0] csr_index,
    input wire logic [7:0] csr_divider,
    input wire logic [3:0] csr_word_length,
    input wire logic csr_hold,
    input wire logic csr_idle_level,
    input wire logic csr_capture_phase,
    input wire logic tx_valid,
    input wire logic [31:0] tx_word,
    output logic tx_ready,
    output logic [15:0] rx_data,
    output logic rx_valid,
    output logic transmit_ready_flag,
    output logic transmit_empty_flag,
    output logic controller_enabled,
    output logic dma_transfer_size,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    input wire logic slave_select_n,
    output logic [3:0] chip_select_n
);
    typedef struct packed {
        spi_quirk_pkg::engine_state_t state;
        logic enabled;
        logic half_reset;
        logic glitch_pending;
        logic resend;
        logic last_flag;
        logic [15:0] shift;
        logic [15:0] rx_shift;
        logic [4:0] bits;
        logic [5:0] edge_cnt;
        logic [5:0] edge_total;
        logic [7:0] div_cnt;
        spi_quirk_pkg::cs_cfg_t cur_cfg;
        logic [1:0] cur_cs;
        logic cs_held;
        logic [1:0] held_cs;
        logic [7:0] prev_div;
        logic sck;
        logic mosi;
        logic drive;
        logic [3:0] cs_n;
        logic tx_rdy;
        logic tx_empty;
        logic [15:0] rx_data;
        logic rx_valid;
        logic dma_size;
        logic sck_d;
        logic [4:0] slv_cnt;
    } ctrl_state_t;

    function automatic ctrl_state_t reset_state();
        ctrl_state_t s;
        s = '0;
        s.cs_n = 4'hF;
        s.tx_rdy = 1'b1;
        s.tx_empty = 1'b1;
        s.prev_div = spi_quirk_pkg::DIV_RESET;
        return s;
    endfunction : reset_state

    ctrl_state_t st_ff;
    ctrl_state_t nxt_st;
    spi_quirk_pkg::cs_cfg_t cfg [spi_quirk_pkg::NUM_CS];
    spi_quirk_pkg::cs_cfg_t cfg_sel;
    spi_quirk_pkg::cs_cfg_t csr_data;
    logic [4:0] bits_sel;
    logic [4:0] bits_cs0;
    logic load_go;
    logic resend_go;
    logic odd_extra;
    logic mixed_extra;
    logic leading;
    logic capture_edge;
    logic release_cs;
    logic mute_cs;
    logic pop;

    word_stream_if #(.W(spi_quirk_pkg::WORD_W)) in_if ();
    word_stream_if #(.W(spi_quirk_pkg::WORD_W)) out_if ();

    assign csr_data = '{divider: csr_divider, word_length: csr_word_length, hold: csr_hold,
        idle_level: csr_idle_level, capture_phase: csr_capture_phase};

    for (genvar i = 0; i < spi_quirk_pkg::NUM_CS; i++) begin : g_cfg
        cs_cfg_reg u_cfg (
            .core_clk(core_clk),
            .reset(reset),
            .clk_en(clk_en),
            .clear(soft_reset_command),
            .wr(csr_write && (csr_index == 2'(i))),
            .wr_data(csr_data),
            .cfg(cfg[i])
        );
    end

    assign in_if.valid = tx_valid;
    assign in_if.data = tx_word;
    assign out_if.ready = pop;

    word_fifo #(.W(spi_quirk_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .flush(soft_reset_command),
        .wr_port(in_if.snk),
        .rd_port(out_if.src)
    );

    assign cfg_sel = cfg[target_select];
    assign bits_sel = 5'(cfg_sel.word_length) + spi_quirk_pkg::BASE_BITS;
    assign bits_cs0 = 5'(cfg[0].word_length) + spi_quirk_pkg::BASE_BITS;
    assign load_go = (st_ff.state == spi_quirk_pkg::st_idle) && st_ff.enabled &&
        master_select_bit && !st_ff.glitch_pending && out_if.valid && !soft_reset_command;
    // An idle gap with the select still held and the fast divider loses the ready edge.
    assign resend_go = st_ff.cs_held && (st_ff.held_cs == target_select) && cfg_sel.hold &&
        (cfg_sel.divider == spi_quirk_pkg::DIV_FAST) && !st_ff.resend;
    assign odd_extra = (cfg_sel.divider == spi_quirk_pkg::DIV_FAST) && bits_sel[0];
    assign mixed_extra = (cfg_sel.divider == spi_quirk_pkg::DIV_FAST) && cfg_sel.idle_level &&
        !cfg_sel.capture_phase && (st_ff.prev_div != spi_quirk_pkg::DIV_FAST);
    assign leading = !st_ff.edge_cnt[0];
    assign capture_edge = (leading == st_ff.cur_cfg.capture_phase) &&
        (st_ff.edge_cnt[5:1] < st_ff.bits);
    assign release_cs = !st_ff.cur_cfg.hold || st_ff.last_flag;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_valid = 1'b0;
        pop = 1'b0;
        mute_cs = 1'b0;
        // In fixed mode the size seen by the DMA always comes from select zero.
        nxt_st.dma_size = ((single_target_mode ? cfg[0].word_length : cfg_sel.word_length)
            != spi_quirk_pkg::LEN_BYTE) ? spi_quirk_pkg::SIZE_HALF
            : spi_quirk_pkg::SIZE_BYTE;
        if (enable_command) begin
            nxt_st.enabled = 1'b1;
        end
        if (disable_command && master_select_bit) begin
            nxt_st.enabled = 1'b0;
        end
        if (csr_write && !master_select_bit) begin
            nxt_st.glitch_pending = 1'b1;
        end
        case (st_ff.state)
            spi_quirk_pkg::st_idle: begin
                nxt_st.sck = cfg_sel.idle_level;
                if (st_ff.enabled && master_select_bit && st_ff.glitch_pending) begin
                    nxt_st.state = spi_quirk_pkg::st_glitch;
                    nxt_st.sck = !cfg_sel.idle_level;
                    nxt_st.glitch_pending = 1'b0;
                end else if (load_go) begin
                    pop = !resend_go;
                    nxt_st.resend = resend_go;
                    nxt_st.tx_rdy = !resend_go;
                    nxt_st.tx_empty = 1'b0;
                    nxt_st.cur_cfg = cfg_sel;
                    nxt_st.cur_cs = target_select;
                    nxt_st.bits = bits_sel;
                    nxt_st.last_flag = out_if.data[spi_quirk_pkg::LAST_XFER_BIT];
                    nxt_st.shift = out_if.data[15:0] << (spi_quirk_pkg::DATA_BITS - bits_sel);
                    nxt_st.mosi = nxt_st.shift[15];
                    nxt_st.rx_shift = '0;
                    nxt_st.edge_cnt = '0;
                    nxt_st.div_cnt = '0;
                    nxt_st.edge_total = 6'({bits_sel, 1'b0}) +
                        ((odd_extra || mixed_extra) ? spi_quirk_pkg::EXTRA_EDGES : 6'h00);
                    nxt_st.state = spi_quirk_pkg::st_lead;
                end
            end
            spi_quirk_pkg::st_lead: begin
                nxt_st.state = spi_quirk_pkg::st_shift;
            end
            spi_quirk_pkg::st_shift: begin
                nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
                if (nxt_st.div_cnt >= st_ff.cur_cfg.divider) begin
                    nxt_st.div_cnt = '0;
                    nxt_st.sck = !st_ff.sck;
                    nxt_st.edge_cnt = st_ff.edge_cnt + 6'h01;
                    if (capture_edge) begin
                        nxt_st.rx_shift = {st_ff.rx_shift[14:0], miso_in};
                    end else if (st_ff.edge_cnt != '0) begin
                        nxt_st.shift = {st_ff.shift[14:0], 1'b0};
                        nxt_st.mosi = nxt_st.shift[15];
                    end
                    if (nxt_st.edge_cnt >= st_ff.edge_total) begin
                        nxt_st.state = spi_quirk_pkg::st_trail;
                    end
                end
            end
            spi_quirk_pkg::st_trail: begin
                nxt_st.rx_data = st_ff.rx_shift;
                nxt_st.rx_valid = 1'b1;
                nxt_st.prev_div = st_ff.cur_cfg.divider;
                nxt_st.tx_empty = !out_if.valid;
                nxt_st.cs_held = !release_cs;
                nxt_st.held_cs = st_ff.cur_cs;
                nxt_st.state = spi_quirk_pkg::st_idle;
            end
            spi_quirk_pkg::st_glitch: begin
                nxt_st.sck = cfg_sel.idle_level;
                nxt_st.state = spi_quirk_pkg::st_idle;
            end
            default: begin
                nxt_st.state = spi_quirk_pkg::st_idle;
            end
        endcase
        // Slave receive uses select zero's length; the pins are already core synchronous.
        nxt_st.sck_d = serial_clock_pin_in;
        if (st_ff.enabled && !master_select_bit) begin
            if (slave_select_n) begin
                nxt_st.slv_cnt = '0;
            end else if (serial_clock_pin_in && !st_ff.sck_d) begin
                nxt_st.rx_shift = {st_ff.rx_shift[14:0], mosi_in};
                nxt_st.slv_cnt = st_ff.slv_cnt + 5'h01;
                if (nxt_st.slv_cnt >= bits_cs0) begin
                    nxt_st.rx_data = nxt_st.rx_shift;
                    nxt_st.rx_valid = 1'b1;
                    nxt_st.slv_cnt = '0;
                end
            end
        end
        // After a lone soft reset the select trails the first clock edge by one cycle.
        mute_cs = st_ff.half_reset && ((nxt_st.state == spi_quirk_pkg::st_lead) ||
            ((nxt_st.state == spi_quirk_pkg::st_shift) && (st_ff.edge_cnt == '0)));
        nxt_st.drive = nxt_st.enabled && master_select_bit;
        nxt_st.cs_n = 4'hF;
        if (nxt_st.drive) begin
            if ((nxt_st.state inside {spi_quirk_pkg::st_lead, spi_quirk_pkg::st_shift,
                spi_quirk_pkg::st_trail}) && !mute_cs) begin
                nxt_st.cs_n[nxt_st.cur_cs] = 1'b0;
            end else if (nxt_st.cs_held) begin
                nxt_st.cs_n[nxt_st.held_cs] = 1'b0;
            end
        end
        if (soft_reset_command) begin
            nxt_st = reset_state();
            nxt_st.half_reset = !st_ff.half_reset;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= reset_state();
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign tx_ready = in_if.ready;
    assign rx_data = st_ff.rx_data;
    assign rx_valid = st_ff.rx_valid;
    assign transmit_ready_flag = st_ff.tx_rdy;
    assign transmit_empty_flag = st_ff.tx_empty;
    assign controller_enabled = st_ff.enabled;
    assign dma_transfer_size = st_ff.dma_size;
    assign serial_clock_pin_out = st_ff.sck;
    assign serial_clock_pin_oe = st_ff.drive;
    assign mosi_out = st_ff.mosi;
    assign mosi_oe = st_ff.drive;
    assign chip_select_n = st_ff.cs_n;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_half_reset_select: assert property (
        (clk_en && st_ff.half_reset && !soft_reset_command && load_go && !st_ff.cs_held)
        ##1 clk_en |=> (chip_select_n == 4'hF))
        else $error("select asserted before first clock after single soft reset");
    a_resend_ready_low: assert property (
        (clk_en && load_go && resend_go) |=> (!transmit_ready_flag && st_ff.resend))
        else $error("ready flag rose on repeated held fast transfer");
    a_last_release: assert property (
        (clk_en && st_ff.state == spi_quirk_pkg::st_trail && st_ff.last_flag &&
        !soft_reset_command) |=> (chip_select_n == 4'hF))
        else $error("held select not released after last transfer");
    a_early_clock: assert property (
        (clk_en && st_ff.state == spi_quirk_pkg::st_idle && st_ff.glitch_pending &&
        st_ff.enabled && master_select_bit && !soft_reset_command)
        |=> (serial_clock_pin_out == !$past(cfg_sel.idle_level)))
        else $error("no stray clock after early select configuration");
    a_dma_size_fixed: assert property (
        (clk_en && single_target_mode && !soft_reset_command)
        |=> (dma_transfer_size == ($past(cfg[0].word_length) != spi_quirk_pkg::LEN_BYTE)))
        else $error("transfer size not taken from select zero");
    a_odd_extra_pulse: assert property (
        (clk_en && load_go && odd_extra)
        |=> (st_ff.edge_total == 6'({$past(bits_sel), 1'b0}) + 6'h02))
        else $error("odd length at fast divider lacks extra pulse");
    a_slave_no_disable: assert property (
        (clk_en && !master_select_bit && st_ff.enabled && disable_command &&
        !soft_reset_command) |=> controller_enabled)
        else $error("slave controller accepted disable");
    a_mixed_div_pulse: assert property (
        (clk_en && load_go && mixed_extra && !odd_extra)
        |=> (st_ff.edge_total == 6'({$past(bits_sel), 1'b0}) + 6'h02))
        else $error("mixed divider case lacks extra pulse");
endmodule : spi_quirk_ctrl

// ==== bench/spi_slave_model.sv ====
`timescale 1ns/100ps
module spi_slave_model (
    input wire logic core_clk,
    input wire logic [3:0] chip_select_n,
    input wire logic serial_clock_pin_out,
    output logic miso_in,
    output logic [15:0] edge_total
);
    logic sck_q;

    // A selected slave answers all ones; once released the line falls to the inverse.
    assign miso_in = (chip_select_n !== 4'hF);

    initial begin
        edge_total = 16'h0000;
        sck_q = 1'b0;
    end

    // Only clock edges seen while some select is low reach the slave, so a late select
    // shows up as a missing edge.
    always @(posedge core_clk) begin
        // Plain inequality keeps the unknown pins before reset from counting as an edge.
        if (serial_clock_pin_out != sck_q && chip_select_n != 4'hF) begin
            edge_total <= edge_total + 16'h0001;
        end
        sck_q <= serial_clock_pin_out;
    end
endmodule : spi_slave_model

// ==== bench/serial_peripheral_port_quirks_tb.sv ====
`timescale 1ns/100ps
module serial_peripheral_port_quirks_tb;
    typedef struct {
        logic [7:0] edges;
        logic [15:0] rx;
        logic chk;
    } exp_t;

    logic core_clk, reset, clk_en, soft_reset_command, enable_command, disable_command;
    logic master_select_bit, single_target_mode, csr_write, csr_hold, tx_valid, tx_ready;
    logic csr_idle_level, csr_capture_phase, rx_valid, transmit_ready_flag;
    logic transmit_empty_flag, controller_enabled, dma_transfer_size, serial_clock_pin_in;
    logic serial_clock_pin_out, mosi_in, miso_in, slave_select_n;
    logic serial_clock_pin_oe, mosi_out, mosi_oe;
    logic [1:0] target_select, csr_index;
    logic [7:0] csr_divider;
    logic [3:0] csr_word_length, chip_select_n;
    logic [31:0] tx_word, r;
    logic [15:0] rx_data, edge_total, prev_edges;
    int seed = 59949;
    int bad_count = 0;
    int checks_done = 0;
    exp_t exp_q[$];
    exp_t cur;

    spi_quirk_ctrl dut_u (.core_clk, .reset, .clk_en, .soft_reset_command, .enable_command,
        .disable_command, .master_select_bit, .single_target_mode, .target_select, .csr_write,
        .csr_index, .csr_divider, .csr_word_length, .csr_hold, .csr_idle_level,
        .csr_capture_phase, .tx_valid, .tx_word, .tx_ready, .rx_data, .rx_valid,
        .transmit_ready_flag, .transmit_empty_flag, .controller_enabled, .dma_transfer_size,
        .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe, .mosi_in,
        .mosi_out, .mosi_oe, .miso_in, .slave_select_n, .chip_select_n);

    spi_slave_model slave_u (.core_clk, .chip_select_n, .serial_clock_pin_out, .miso_in,
        .edge_total);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic cmd(input int k);
        soft_reset_command = (k == 0);
        enable_command = (k == 1);
        disable_command = (k == 2);
        cyc(1);
        soft_reset_command = 1'b0;
        enable_command = 1'b0;
        disable_command = 1'b0;
        cyc(2);
    endtask : cmd

    task automatic cfg(input logic [1:0] i, input logic [7:0] d, input logic [3:0] l,
                       input logic h);
        csr_write = 1'b1;
        csr_index = i;
        csr_divider = d;
        csr_word_length = l;
        csr_hold = h;
        cyc(1);
        csr_write = 1'b0;
        cyc(1);
    endtask : cfg

    // A count of zero pushes without waiting for room and expects the word to be dropped.
    task automatic push(input logic last, input logic [7:0] e, input logic [15:0] rx,
                        input logic chk, input int n);
        exp_t x;
        int b;
        b = 0;
        while (n > 0 && tx_ready !== 1'b1 && b < 100) begin
            cyc(1);
            b++;
        end
        if (b == 100) begin
            bad_count++;
            complete_run();
        end
        r = $random(seed);
        tx_word = (32'(last) << spi_quirk_pkg::LAST_XFER_BIT) | 32'(r[15:0]);
        mosi_in = r[16];
        tx_valid = 1'b1;
        for (int k = 0; k < n; k++) begin
            x.edges = e;
            x.rx = rx;
            x.chk = chk;
            exp_q.push_back(x);
        end
        cyc(1);
        tx_valid = 1'b0;
        cyc(1);
    endtask : push

    task automatic wait_idle();
        int b;
        b = 0;
        while ((exp_q.size() != 0 || transmit_empty_flag !== 1'b1) && b < 4000) begin
            cyc(1);
            b++;
        end
        if (b == 4000) begin
            bad_count++;
            complete_run();
        end
        cyc(4);
    endtask : wait_idle

    always @(posedge core_clk) begin
        if (reset === 1'b0 && rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                cur = exp_q.pop_front();
                if (cur.chk) check(rx_data, cur.rx);
                check(edge_total - prev_edges, cur.edges);
            end
            prev_edges = edge_total;
        end
    end

    initial begin
        {soft_reset_command, enable_command, disable_command, csr_write, tx_valid} = 5'h00;
        {csr_hold, csr_idle_level, csr_capture_phase, serial_clock_pin_in, mosi_in} = 5'h00;
        {single_target_mode, target_select, csr_index} = 5'h00;
        {csr_divider, csr_word_length, tx_word} = 44'h0;
        clk_en = 1'b1;
        slave_select_n = 1'b1;
        master_select_bit = 1'b1;
        prev_edges = 16'h0000;
        reset = 1'b1;
        cyc(20);
        reset = 1'b0;
        check({chip_select_n, tx_ready, transmit_ready_flag, transmit_empty_flag,
               controller_enabled, dma_transfer_size, serial_clock_pin_out,
               serial_clock_pin_oe, mosi_out, mosi_oe}, {4'hF, 5'h1C, 4'h0});
        // Fill the buffer while disabled, then drain it.
        for (int k = 0; k < spi_quirk_pkg::FIFO_DEPTH; k++) push(1'b0, 8'h10, 16'h00FF, 1'b1, 1);
        check(tx_ready, 1'b0);
        push(1'b0, 8'h10, 16'h00FF, 1'b1, 0);
        cmd(1);
        check({controller_enabled, serial_clock_pin_oe, mosi_oe}, 3'h7);
        wait_idle();
        check(transmit_empty_flag, 1'b1);
        // A lone soft reset loses the first clock edge; a second one restores it.
        cmd(0);
        check({controller_enabled, chip_select_n}, 5'h0F);
        cmd(1);
        push(1'b0, 8'h0F, 16'h0000, 1'b0, 1);
        wait_idle();
        cmd(0);
        cmd(1);
        push(1'b0, 8'h10, 16'h00FF, 1'b1, 1);
        wait_idle();
        for (int l = 0; l < 4; l++) begin
            cfg(2'h0, spi_quirk_pkg::DIV_ONE, l[3:0], 1'b0);
            push(1'b0, 8'(2 * (l + 8) + ((l % 2) * 2)), 16'((1 << (l + 8)) - 1), 1'b1, 1);
            wait_idle();
        end
        master_select_bit = 1'b0;
        cmd(2);
        check(controller_enabled, 1'b1);
        cmd(0);
        cmd(0);
        check(controller_enabled, 1'b0);
        // Configure while still a slave so the switch to master shows the stray clock.
        cfg(2'h2, 8'h02, spi_quirk_pkg::LEN_BYTE, 1'b0);
        master_select_bit = 1'b1;
        enable_command = 1'b1;
        cyc(1);
        enable_command = 1'b0;
        cyc(1);
        check({serial_clock_pin_out, chip_select_n}, 5'h1F);
        cyc(2);
        single_target_mode = 1'b1;
        target_select = 2'h1;
        cfg(2'h1, 8'h02, spi_quirk_pkg::LEN_BYTE, 1'b1);
        cfg(2'h0, 8'h02, 4'h2, 1'b0);
        cyc(3);
        check(dma_transfer_size, spi_quirk_pkg::SIZE_HALF);
        cfg(2'h0, 8'h02, spi_quirk_pkg::LEN_BYTE, 1'b0);
        cyc(3);
        check(dma_transfer_size, spi_quirk_pkg::SIZE_BYTE);
        push(1'b0, 8'h10, 16'h00FF, 1'b1, 1);
        wait_idle();
        check(chip_select_n, 4'hD);
        push(1'b1, 8'h10, 16'h00FF, 1'b1, 1);
        wait_idle();
        check(chip_select_n, 4'hF);
        // A slow select followed by a fast one with the clock idling high adds a pulse.
        csr_idle_level = 1'b1;
        cfg(2'h1, spi_quirk_pkg::DIV_ONE, spi_quirk_pkg::LEN_BYTE, 1'b0);
        push(1'b0, 8'h12, 16'h00FF, 1'b1, 1);
        wait_idle();
        csr_idle_level = 1'b0;
        single_target_mode = 1'b0;
        target_select = 2'h0;
        // Held select at the fastest divider: the second word after an idle gap goes twice.
        cfg(2'h0, spi_quirk_pkg::DIV_ONE, spi_quirk_pkg::LEN_BYTE, 1'b1);
        push(1'b0, 8'h10, 16'h00FF, 1'b1, 1);
        wait_idle();
        push(1'b0, 8'h10, 16'h00FF, 1'b1, 2);
        wait_idle();
        cyc(20);
        cmd(0);
        cmd(0);
        check(chip_select_n, 4'hF);
        check(exp_q.size(), 32'h0);
        complete_run();
    end
endmodule : serial_peripheral_port_quirks_tb
